// file: rtl/stap_regs.vh
`ifndef STAP_REGS_VH
`define STAP_REGS_VH
// ----------------------------------------
// instruction codes
// ----------------------------------------
`define STAP_IR_W 3
`define STAP_IR_EXTEST 3'h0
`define STAP_IR_IDCODE 3'h1
`define STAP_IR_SAMPZ 3'h2
`define STAP_IR_RFU0 3'h3
`define STAP_IR_SAMPLE 3'h4
`define STAP_IR_PRIV 3'h5
`define STAP_IR_RFU1 3'h6
`define STAP_IR_BYPASS 3'h7
`define STAP_IR_CAPT 3'h1
// ----------------------------------------
// id register
// ----------------------------------------
`define STAP_ID_W 32
// arbitrary neutral identification value
`define STAP_ID_VAL 32'h00000001
// ----------------------------------------
// tap states (one-hot bit index)
// ----------------------------------------
`define STAP_NST 16
`define STAP_S_TLR 0
`define STAP_S_RTI 1
`define STAP_S_SDR 2
`define STAP_S_CDR 3
`define STAP_S_SHDR 4
`define STAP_S_E1DR 5
`define STAP_S_PDR 6
`define STAP_S_E2DR 7
`define STAP_S_UDR 8
`define STAP_S_SIR 9
`define STAP_S_CIR 10
`define STAP_S_SHIR 11
`define STAP_S_E1IR 12
`define STAP_S_PIR 13
`define STAP_S_E2IR 14
`define STAP_S_UIR 15
// ----------------------------------------
// pin synchroniser bit positions
// ----------------------------------------
`define STAP_SYNC_W 5
`define STAP_SYNC_RST 5'h1F
`define STAP_SY_TCK 4
`define STAP_SY_TMS 3
`define STAP_SY_TMSD 2
`define STAP_SY_TDI 1
`define STAP_SY_TDID 0
`endif

// file: rtl/stap_tap.v
`timescale 1ns/10ps
`default_nettype none
`include "stap_regs.vh"
module stap_tap #(
  parameter PIN_W = 8,
  parameter PAD_W = 2
) (
  // system
  input wire clk_sys,
  input wire rst_n,
  // test pins, tms and tdi each with a drive-present flag
  input wire tck_in,
  input wire tms_in,
  input wire tms_drv,
  input wire tdi_in,
  input wire tdi_drv,
  output reg tdo_out_q,
  output reg tdo_oe_q,
  // memory pin ring
  input wire [PIN_W-1:0] ring_in,
  output reg [PIN_W-1:0] ring_out_q,
  output reg ring_oe_q,
  output reg ring_hiz_q
);
  localparam BSR_W = PIN_W + PAD_W;

  // ----------------------------------------
  // synchronisers and edge detect
  // ----------------------------------------
  reg [`STAP_SYNC_W-1:0] s1_q;
  reg [`STAP_SYNC_W-1:0] s2_q;
  reg [PIN_W-1:0] ring_s1_q;
  reg [PIN_W-1:0] ring_s2_q;
  reg tck_d1_q;
  wire tms_v;
  wire tdi_v;
  wire tck_rise;
  wire tck_fall;
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      s1_q <= `STAP_SYNC_RST;
      s2_q <= `STAP_SYNC_RST;
      ring_s1_q <= {PIN_W{1'b0}};
      ring_s2_q <= {PIN_W{1'b0}};
      tck_d1_q <= 1'b1; // same as synced tck reset, no false rise
    end
    else
    begin
      s1_q <= {tck_in, tms_in, tms_drv, tdi_in, tdi_drv};
      s2_q <= s1_q;
      ring_s1_q <= ring_in;
      ring_s2_q <= ring_s1_q;
      tck_d1_q <= s2_q[`STAP_SY_TCK];
    end
  end
  assign tms_v = s2_q[`STAP_SY_TMS] | ~s2_q[`STAP_SY_TMSD];
  assign tdi_v = s2_q[`STAP_SY_TDI] | ~s2_q[`STAP_SY_TDID];
  assign tck_rise = s2_q[`STAP_SY_TCK] & ~tck_d1_q;
  assign tck_fall = ~s2_q[`STAP_SY_TCK] & tck_d1_q;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function is_bsr;
    input [2:0] ir;
    begin
      is_bsr = (ir == `STAP_IR_EXTEST) || (ir == `STAP_IR_SAMPZ) ||
               (ir == `STAP_IR_SAMPLE);
    end
  endfunction

  // ----------------------------------------
  // tap state machine
  // ----------------------------------------
  localparam [`STAP_NST-1:0] S_ONE = {{(`STAP_NST-1){1'b0}}, 1'b1};
  localparam [`STAP_NST-1:0] S_TLR = S_ONE << `STAP_S_TLR;
  localparam [`STAP_NST-1:0] S_RTI = S_ONE << `STAP_S_RTI;
  localparam [`STAP_NST-1:0] S_SDR = S_ONE << `STAP_S_SDR;
  localparam [`STAP_NST-1:0] S_CDR = S_ONE << `STAP_S_CDR;
  localparam [`STAP_NST-1:0] S_SHDR = S_ONE << `STAP_S_SHDR;
  localparam [`STAP_NST-1:0] S_E1DR = S_ONE << `STAP_S_E1DR;
  localparam [`STAP_NST-1:0] S_PDR = S_ONE << `STAP_S_PDR;
  localparam [`STAP_NST-1:0] S_E2DR = S_ONE << `STAP_S_E2DR;
  localparam [`STAP_NST-1:0] S_UDR = S_ONE << `STAP_S_UDR;
  localparam [`STAP_NST-1:0] S_SIR = S_ONE << `STAP_S_SIR;
  localparam [`STAP_NST-1:0] S_CIR = S_ONE << `STAP_S_CIR;
  localparam [`STAP_NST-1:0] S_SHIR = S_ONE << `STAP_S_SHIR;
  localparam [`STAP_NST-1:0] S_E1IR = S_ONE << `STAP_S_E1IR;
  localparam [`STAP_NST-1:0] S_PIR = S_ONE << `STAP_S_PIR;
  localparam [`STAP_NST-1:0] S_E2IR = S_ONE << `STAP_S_E2IR;
  localparam [`STAP_NST-1:0] S_UIR = S_ONE << `STAP_S_UIR;
  reg [`STAP_NST-1:0] st_q;
  reg [`STAP_NST-1:0] st_d;
  always @*
  begin
    case (st_q)
      S_TLR: st_d = tms_v ? S_TLR : S_RTI;
      S_RTI: st_d = tms_v ? S_SDR : S_RTI;
      S_SDR: st_d = tms_v ? S_SIR : S_CDR;
      S_CDR: st_d = tms_v ? S_E1DR : S_SHDR;
      S_SHDR: st_d = tms_v ? S_E1DR : S_SHDR;
      S_E1DR: st_d = tms_v ? S_UDR : S_PDR;
      S_PDR: st_d = tms_v ? S_E2DR : S_PDR;
      S_E2DR: st_d = tms_v ? S_UDR : S_SHDR;
      S_UDR: st_d = tms_v ? S_SDR : S_RTI;
      S_SIR: st_d = tms_v ? S_TLR : S_CIR;
      S_CIR: st_d = tms_v ? S_E1IR : S_SHIR;
      S_SHIR: st_d = tms_v ? S_E1IR : S_SHIR;
      S_E1IR: st_d = tms_v ? S_UIR : S_PIR;
      S_PIR: st_d = tms_v ? S_E2IR : S_PIR;
      S_E2IR: st_d = tms_v ? S_UIR : S_SHIR;
      S_UIR: st_d = tms_v ? S_SDR : S_RTI;
      default: st_d = S_TLR;
    endcase
  end

  // ----------------------------------------
  // registers on the rising test-clock edge
  // ----------------------------------------
  reg [2:0] ir_sh_q;
  reg [2:0] ir_q;
  reg byp_q;
  reg [`STAP_ID_W-1:0] id_q;
  reg [BSR_W-1:0] bsr_q;
  reg [BSR_W-1:0] bsr_upd_q;
  wire sel_bsr;
  wire sel_id;
  wire sel_byp;
  assign sel_bsr = is_bsr(ir_q);
  assign sel_id = (ir_q == `STAP_IR_IDCODE);
  assign sel_byp = ~sel_bsr & ~sel_id;

  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st_q <= S_TLR;
      ir_sh_q <= `STAP_IR_IDCODE;
      ir_q <= `STAP_IR_IDCODE;
      byp_q <= 1'b0;
      id_q <= {`STAP_ID_W{1'b0}};
      bsr_q <= {BSR_W{1'b1}};
      bsr_upd_q <= {BSR_W{1'b1}};
    end
    else if (tck_rise)
    begin
      st_q <= st_d;
      if (st_q[`STAP_S_TLR])
        ir_q <= `STAP_IR_IDCODE;
      if (st_q[`STAP_S_CIR])
        ir_sh_q <= `STAP_IR_CAPT;
      if (st_q[`STAP_S_SHIR])
        ir_sh_q <= {tdi_v, ir_sh_q[2:1]};
      if (st_q[`STAP_S_UIR])
        ir_q <= ir_sh_q;
      if (st_q[`STAP_S_CDR])
      begin
        byp_q <= 1'b0;
        if (sel_id)
          id_q <= `STAP_ID_VAL;
        if (sel_bsr)
          bsr_q <= {{PAD_W{1'b1}}, ring_s2_q};
      end
      if (st_q[`STAP_S_SHDR])
      begin
        if (sel_byp)
          byp_q <= tdi_v;
        if (sel_id)
          id_q <= {tdi_v, id_q[`STAP_ID_W-1:1]};
        if (sel_bsr)
          bsr_q <= {tdi_v, bsr_q[BSR_W-1:1]};
      end
      if (st_q[`STAP_S_UDR] && sel_bsr)
        bsr_upd_q <= bsr_q | {{PAD_W{1'b1}}, {PIN_W{1'b0}}};
    end
  end

  // ----------------------------------------
  // outputs on the falling test-clock edge
  // ----------------------------------------
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      tdo_out_q <= 1'b0;
      tdo_oe_q <= 1'b0;
      ring_out_q <= {PIN_W{1'b0}};
      ring_oe_q <= 1'b0;
      ring_hiz_q <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo_oe_q <= st_q[`STAP_S_SHDR] | st_q[`STAP_S_SHIR];
      if (st_q[`STAP_S_SHIR])
        tdo_out_q <= ir_sh_q[0];
      else if (sel_bsr)
        tdo_out_q <= bsr_q[0];
      else if (sel_id)
        tdo_out_q <= id_q[0];
      else
        tdo_out_q <= byp_q;
      ring_out_q <= bsr_upd_q[PIN_W-1:0];
      ring_oe_q <= (ir_q == `STAP_IR_EXTEST);
      ring_hiz_q <= (ir_q == `STAP_IR_SAMPZ);
    end
  end
endmodule // stap_tap
`default_nettype wire

// file: tb/stap_tap_checker.sv
`timescale 1ns/10ps
`default_nettype none
module stap_tap_checker #(
  parameter PIN_W = 8
) (
  // system
  input wire logic clk_sys,
  input wire logic rst_n,
  // scan and ring pins
  input wire logic tck_in,
  input wire logic tdo_out_q,
  input wire logic tdo_oe_q,
  input wire logic [PIN_W-1:0] ring_out_q,
  input wire logic ring_oe_q,
  input wire logic ring_hiz_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence tck_still;
    $stable(tck_in) [*8];
  endsequence
  tdo_on_fall_a: assert property ($changed(tdo_out_q) |-> !tck_in)
    else $error("tdo moved while tck high");
  oe_on_fall_a: assert property ($changed(tdo_oe_q) |-> !tck_in)
    else $error("tdo enable moved while tck high");
  ring_on_fall_a: assert property ($changed(ring_out_q) |-> !tck_in)
    else $error("ring data moved while tck high");
  drive_on_fall_a: assert property ($changed(ring_oe_q) |-> !tck_in)
    else $error("ring drive moved while tck high");
  hiz_on_fall_a: assert property ($changed(ring_hiz_q) |-> !tck_in)
    else $error("ring hiz moved while tck high");
  mode_excl_a: assert property (!(ring_oe_q && ring_hiz_q))
    else $error("drive and hiz both set");
  idle_quiet_a: assert property (tck_still |=> $stable({tdo_out_q, tdo_oe_q}))
    else $error("tdo moved without tck edges");
  reset_off_a: assert property (disable iff (1'b0)
    !rst_n |=> !tdo_oe_q && !ring_oe_q && !ring_hiz_q)
    else $error("outputs active after reset");
endmodule // stap_tap_checker
bind stap_tap stap_tap_checker #(.PIN_W(PIN_W)) stap_tap_checker_inst (
  .clk_sys(clk_sys), .rst_n(rst_n), .tck_in(tck_in), .tdo_out_q(tdo_out_q),
  .tdo_oe_q(tdo_oe_q), .ring_out_q(ring_out_q), .ring_oe_q(ring_oe_q),
  .ring_hiz_q(ring_hiz_q));
`default_nettype wire

// file: tb/stap_master.sv
`timescale 1ns/10ps
`default_nettype none
module stap_master (
  // scan pins
  output logic tck,
  output logic tms,
  output logic tms_drv,
  output logic tdi,
  output logic tdi_drv,
  input wire logic tdo,
  input wire logic tdo_oe
);
  logic tms_en = 1'b1;
  logic tdi_en = 1'b1;
  logic tms_v = 1'b1;
  logic tdi_v = 1'b1;
  // released lines show the inverse
  assign tms_drv = tms_en;
  assign tdi_drv = tdi_en;
  assign tms = tms_en ? tms_v : !tms_v;
  assign tdi = tdi_en ? tdi_v : !tdi_v;
  initial tck = 1'b0;
  // one tck period, tdo taken just before the rise
  task automatic step(input logic m, input logic d, output logic o, output logic oe);
    tms_v = m;
    tdi_v = d;
    #62;
    o = tdo;
    oe = tdo_oe;
    #0.5 tck = 1'b1;
    #62.5 tck = 1'b0;
  endtask
endmodule // stap_master
`default_nettype wire

// file: tb/tb_stap_tap.sv
`timescale 1ns/10ps
`default_nettype none
`include "stap_regs.vh"
module tb_stap_tap;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] ring_in = 8'hA5;
  logic o, oe;
  wire tck, tms, tms_drv, tdi, tdi_drv, tdo, tdo_oe, ring_oe, ring_hiz;
  wire [7:0] ring_out;
  int n_fail = 0;
  int total_checks = 0;
  always #5 clk_sys = !clk_sys;
  stap_tap #(.PIN_W(8), .PAD_W(2)) stap_tap_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .tck_in(tck), .tms_in(tms), .tms_drv(tms_drv), .tdi_in(tdi), .tdi_drv(tdi_drv),
    .tdo_out_q(tdo), .tdo_oe_q(tdo_oe), .ring_in(ring_in), .ring_out_q(ring_out),
    .ring_oe_q(ring_oe), .ring_hiz_q(ring_hiz));
  stap_master stap_master_inst (.tck(tck), .tms(tms), .tms_drv(tms_drv), .tdi(tdi),
    .tdi_drv(tdi_drv), .tdo(tdo), .tdo_oe(tdo_oe));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic st(input logic m, input logic d);
    stap_master_inst.step(m, d, o, oe);
  endtask
  // idle to shift, n bits, update, back to idle
  task automatic scan(input logic ir, input logic [63:0] din, input int n,
    output logic [63:0] dout);
    dout = '0;
    st(1'b1, 1'b1);
    if (ir) st(1'b1, 1'b1);
    st(1'b0, 1'b1);
    st(1'b0, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      stap_master_inst.step(i == n - 1, din[i], dout[i], oe);
      chk(oe, 1'b1);
    end
    st(1'b1, 1'b1);
    st(1'b0, 1'b1);
    chk(oe, 1'b0);
  endtask
  task automatic t_id;
    logic [63:0] d;
    st(1'b0, 1'b1);
    chk({ring_oe, ring_hiz}, 2'h0);
    scan(1'b0, '1, 32, d);
    chk(d[31:0], `STAP_ID_VAL);
    $display("t_id done");
  endtask
  task automatic t_byp;
    logic [63:0] d;
    logic [2:0] c[4] = '{3'h3, 3'h5, 3'h6, 3'h7};
    foreach (c[k])
    begin
      scan(1'b1, {61'h0, c[k]}, 3, d);
      chk(d[2:0], 3'h1);
      scan(1'b0, 64'h5, 4, d);
      chk(d[3:1], 3'h5);
    end
    $display("t_byp done");
  endtask
  task automatic t_bsr;
    logic [63:0] d;
    logic [2:0] c[3] = '{3'h0, 3'h2, 3'h4};
    foreach (c[k])
    begin
      @(negedge clk_sys);
      ring_in = 8'h5A ^ {5'h0, c[k]};
      scan(1'b1, {61'h0, c[k]}, 3, d);
      st(1'b0, 1'b1);
      chk({ring_oe, ring_hiz}, {c[k] == 3'h0, c[k] == 3'h2});
      scan(1'b0, {56'h0, ~ring_in}, 10, d);
      chk(d[9:0], {2'b11, ring_in});
      st(1'b0, 1'b1);
      chk(ring_out, {~ring_in});
    end
    $display("t_bsr done");
  endtask
  task automatic t_undrv;
    logic [63:0] d;
    scan(1'b1, 64'h7, 3, d);
    chk(d[2:0], 3'h1);
    stap_master_inst.tdi_en = 1'b0;
    scan(1'b0, '1, 4, d);
    chk(d[3:1], 3'h7);
    stap_master_inst.tdi_en = 1'b1;
    stap_master_inst.tms_en = 1'b0;
    repeat (5) st(1'b1, 1'b1);
    stap_master_inst.tms_en = 1'b1;
    st(1'b0, 1'b1);
    scan(1'b0, '1, 32, d);
    chk(d[31:0], `STAP_ID_VAL);
    $display("t_undrv done");
  endtask
  task automatic test_done;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(negedge clk_sys);
    rst_n = 1'b1;
    t_id();
    t_byp();
    t_bsr();
    t_undrv();
    test_done();
  end
  initial
  begin
    #900000;
    n_fail++;
    test_done();
  end
endmodule // tb_stap_tap
`default_nettype wire
